/* File: rtl/isrb_slave_rx.sv */
`timescale 1ns/1ns
`include "isrb_regs.svh"

// Operation
// - Nack selector clear: acknowledge every data byte
// - Never receive more than byte_count bytes, except one byte when byte_count is zero
// - Nack selector set: release data after last
// - Ack enable clear: ignore own address
// - Monitor bus; ack enable resumes recognition anytime
// - Addressing codes 60h, 68h, D8h reported
// - Only final counted byte nacked, unless terminated
// - Accept fewer bytes on early stop/restart
// - Own write address sets flag, interrupt, 60h
// - General call enabled: receive, report D0h
module isrb_slave_rx
  import isrb_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire isrb_bus_req_t bus_req,
  output logic [7:0]         rdata,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  input  wire logic          arb_lost,
  output logic               scl_out,
  output logic               scl_oe_n,
  output logic               sda_out,
  output logic               sda_oe_n,
  output logic               int_n,
  output logic               irq
);
  logic [1:0]  pin_lvl;
  isrb_cond_t  cond;
  isrb_state_t state_r, state_nxt;
  logic [3:0]  bit_cnt_r, bit_cnt_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [6:0]  rx_cnt_r, rx_cnt_nxt;
  logic [6:0]  rx_inc;
  logic        gc_r, gc_nxt;
  logic        last_r, last_nxt;
  logic        acked_r, acked_nxt;
  logic        sda_oe_n_r, sda_oe_n_nxt;
  logic        scl_oe_n_r, scl_oe_n_nxt;
  logic [7:0]  status_r, status_nxt;
  logic        si_set, seq_start, buf_we;
  logic [2:0]  ev;
  logic        own_hit, gc_hit, last_w;
  logic        aa_r, aa_nxt, en_r, en_nxt;
  logic        si_r, si_nxt, mode_r, mode_nxt;
  logic        lb_r, lb_nxt;
  logic [6:0]  bc_r, bc_nxt;
  logic [7:0]  own_r, own_nxt;
  logic [2:0]  irq_stat_r, irq_stat_nxt;
  logic [2:0]  irq_mask_r, irq_mask_nxt;
  logic [6:0]  rd_ptr_r, rd_ptr_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        irq_r, irq_nxt, int_n_r, int_n_nxt;
  logic [7:0]  rd_mux, ctrl_rd;
  logic [7:0]  buf_r [0:`ISRB_BUF_DEPTH-1];
  logic        wr_ctrl, wr_xfer, wr_own, wr_stat, wr_mask, rd_data;

  isrb_sync3 u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .pin_in   ({scl_in, sda_in}),
    .level    (pin_lvl)
  );
  isrb_cond_det u_cond (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .scl      (pin_lvl[1]),
    .sda      (pin_lvl[0]),
    .cond     (cond)
  );
  // Recognition uses the live enables, so software may flip them anytime
  assign own_hit = en_r && aa_r && (shift_r[7:1] == own_r[7:1])
                   && !shift_r[0];
  assign gc_hit  = en_r && own_r[`ISRB_OWN_GC]
                   && (shift_r == `ISRB_GC_ADDR);
  assign rx_inc  = rx_cnt_r + 7'h01;
  // Buffer depth also caps the count when byte_count exceeds it
  assign last_w  = (rx_inc >= bc_r) || (rx_inc == `ISRB_BUF_DEPTH);

  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    shift_nxt    = shift_r;
    rx_cnt_nxt   = rx_cnt_r;
    gc_nxt       = gc_r;
    last_nxt     = last_r;
    acked_nxt    = acked_r;
    sda_oe_n_nxt = sda_oe_n_r;
    scl_oe_n_nxt = scl_oe_n_r;
    status_nxt   = status_r;
    si_set       = 1'b0;
    seq_start    = 1'b0;
    buf_we       = 1'b0;
    ev           = 3'h0;
    if (cond.stop || cond.start) begin
      if (state_r inside {ST_ADDR_ACK, ST_HOLD, ST_DATA, ST_DATA_ACK}) begin
        status_nxt          = `ISRB_SC_STOP;
        si_set              = 1'b1;
        ev[`ISRB_IRQ_STOP]  = 1'b1;
      end
      state_nxt    = cond.start ? ST_ADDR : ST_IDLE;
      bit_cnt_nxt  = 4'h0;
      sda_oe_n_nxt = 1'b1;
      scl_oe_n_nxt = 1'b1;
    end else begin
      case (state_r)
        ST_ADDR: begin
          if (cond.scl_rise && bit_cnt_r != `ISRB_BITS_BYTE) begin
            shift_nxt   = {shift_r[6:0], pin_lvl[0]};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (cond.scl_fall && bit_cnt_r == `ISRB_BITS_BYTE) begin
            bit_cnt_nxt = 4'h0;
            if (own_hit || gc_hit) begin
              gc_nxt       = gc_hit && !own_hit;
              sda_oe_n_nxt = 1'b0;
              state_nxt    = ST_ADDR_ACK;
            end else begin
              state_nxt    = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (cond.scl_fall) begin
            sda_oe_n_nxt       = 1'b1;
            scl_oe_n_nxt       = 1'b0;
            si_set             = 1'b1;
            ev[`ISRB_IRQ_ADDR] = 1'b1;
            state_nxt          = ST_HOLD;
            if (gc_r) begin
              status_nxt = arb_lost ? `ISRB_SC_ARB_GC
                                    : `ISRB_SC_GC;
            end else begin
              status_nxt = arb_lost ? `ISRB_SC_ARB_SLA_W
                                    : `ISRB_SC_SLA_W;
            end
          end
        end
        ST_HOLD: begin
          // Clock is stretched until software clears the flag with the mode bit set
          if (!si_r && mode_r) begin
            scl_oe_n_nxt = 1'b1;
            seq_start    = 1'b1;
            rx_cnt_nxt   = 7'h00;
            bit_cnt_nxt  = 4'h0;
            state_nxt    = ST_DATA;
          end
        end
        ST_DATA: begin
          if (cond.scl_rise && bit_cnt_r != `ISRB_BITS_BYTE) begin
            shift_nxt   = {shift_r[6:0], pin_lvl[0]};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (cond.scl_fall && bit_cnt_r == `ISRB_BITS_BYTE) begin
            buf_we       = 1'b1;
            rx_cnt_nxt   = rx_inc;
            bit_cnt_nxt  = 4'h0;
            last_nxt     = last_w;
            acked_nxt    = !(last_w && lb_r);
            sda_oe_n_nxt = last_w && lb_r;
            state_nxt    = ST_DATA_ACK;
          end
        end
        ST_DATA_ACK: begin
          if (cond.scl_fall) begin
            sda_oe_n_nxt = 1'b1;
            if (!last_r) begin
              state_nxt = ST_DATA;
            end else begin
              si_set            = 1'b1;
              ev[`ISRB_IRQ_SEQ] = 1'b1;
              if (acked_r) begin
                status_nxt   = `ISRB_SC_RX_ACK;
                scl_oe_n_nxt = 1'b0;
                state_nxt    = ST_HOLD;
              end else begin
                status_nxt = `ISRB_SC_RX_NACK;
                state_nxt  = ST_IGNORE;
              end
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          state_nxt = state_r;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      rx_cnt_r   <= 7'h00;
      gc_r       <= 1'b0;
      last_r     <= 1'b0;
      acked_r    <= 1'b0;
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
      status_r   <= `ISRB_SC_IDLE;
    end else if (ce) begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      gc_r       <= gc_nxt;
      last_r     <= last_nxt;
      acked_r    <= acked_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
      scl_oe_n_r <= scl_oe_n_nxt;
      status_r   <= status_nxt;
    end
  end

  // Storage needs no reset; entries are read only after being written
  always_ff @(posedge core_clk) begin
    if (ce && buf_we) begin
      buf_r[rx_cnt_r] <= shift_r;
    end
  end
  assign wr_ctrl = bus_req.wr && bus_req.addr == `ISRB_OFS_CTRL;
  assign wr_xfer = bus_req.wr && bus_req.addr == `ISRB_OFS_XFER;
  assign wr_own  = bus_req.wr && bus_req.addr == `ISRB_OFS_OWNADR;
  assign wr_stat = bus_req.wr && bus_req.addr == `ISRB_OFS_IRQ_STAT;
  assign wr_mask = bus_req.wr && bus_req.addr == `ISRB_OFS_IRQ_MASK;
  assign rd_data = bus_req.rd && bus_req.addr == `ISRB_OFS_DATA;

  always_comb begin
    aa_nxt   = wr_ctrl ? bus_req.wdata[`ISRB_CTRL_AA] : aa_r;
    en_nxt   = wr_ctrl ? bus_req.wdata[`ISRB_CTRL_EN] : en_r;
    mode_nxt = wr_ctrl ? bus_req.wdata[`ISRB_CTRL_MODE] : mode_r;
    // Writing zero clears the flag; a hardware set in that cycle wins
    si_nxt   = si_set || (si_r && !(wr_ctrl
               && !bus_req.wdata[`ISRB_CTRL_SI]));
    lb_nxt   = wr_xfer ? bus_req.wdata[`ISRB_XFER_LB] : lb_r;
    bc_nxt   = wr_xfer ? bus_req.wdata[6:0] : bc_r;
    own_nxt  = wr_own ? bus_req.wdata : own_r;
    irq_stat_nxt = ev | (irq_stat_r
                   & ~(wr_stat ? bus_req.wdata[2:0] : 3'h0));
    irq_mask_nxt = wr_mask ? bus_req.wdata[2:0] : irq_mask_r;
    rd_ptr_nxt = rd_ptr_r;
    if (seq_start) begin
      rd_ptr_nxt = 7'h00;
    end else if (rd_data && rd_ptr_r != `ISRB_BUF_DEPTH - 7'h01) begin
      rd_ptr_nxt = rd_ptr_r + 7'h01;
    end
    ctrl_rd = 8'h00;
    ctrl_rd[`ISRB_CTRL_AA]   = aa_r;
    ctrl_rd[`ISRB_CTRL_EN]   = en_r;
    ctrl_rd[`ISRB_CTRL_SI]   = si_r;
    ctrl_rd[`ISRB_CTRL_MODE] = mode_r;
    case (bus_req.addr)
      `ISRB_OFS_CTRL:     rd_mux = ctrl_rd;
      `ISRB_OFS_STATUS:   rd_mux = status_r;
      `ISRB_OFS_XFER:     rd_mux = {lb_r, bc_r};
      `ISRB_OFS_OWNADR:   rd_mux = own_r;
      `ISRB_OFS_DATA:     rd_mux = buf_r[rd_ptr_r];
      `ISRB_OFS_IRQ_STAT: rd_mux = {5'h00, irq_stat_r};
      `ISRB_OFS_IRQ_MASK: rd_mux = {5'h00, irq_mask_r};
      `ISRB_OFS_RXCNT:    rd_mux = {1'b0, rx_cnt_r};
      default:            rd_mux = 8'h00;
    endcase
    rdata_nxt = bus_req.rd ? rd_mux : 8'h00;
    irq_nxt   = |(irq_stat_nxt & irq_mask_nxt);
    int_n_nxt = !si_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aa_r       <= 1'(`ISRB_CTRL_RST >> `ISRB_CTRL_AA);
      en_r       <= 1'b0;
      si_r       <= 1'b0;
      mode_r     <= 1'b0;
      lb_r       <= 1'b0;
      bc_r       <= 7'h00;
      own_r      <= `ISRB_OWNADR_RST;
      irq_stat_r <= 3'h0;
      irq_mask_r <= `ISRB_MASK_RST;
      rd_ptr_r   <= 7'h00;
      rdata_r    <= 8'h00;
      irq_r      <= 1'b0;
      int_n_r    <= 1'b1;
    end else if (ce) begin
      aa_r       <= aa_nxt;
      en_r       <= en_nxt;
      si_r       <= si_nxt;
      mode_r     <= mode_nxt;
      lb_r       <= lb_nxt;
      bc_r       <= bc_nxt;
      own_r      <= own_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      rd_ptr_r   <= rd_ptr_nxt;
      rdata_r    <= rdata_nxt;
      irq_r      <= irq_nxt;
      int_n_r    <= int_n_nxt;
    end
  end

  // Open-drain: only the enables move, the driven level is always low
  assign rdata    = rdata_r;
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;
  assign int_n    = int_n_r;
  assign irq      = irq_r;

  logic data_end, addr_end, quiet;
  assign quiet    = ce && !cond.stop && !cond.start;
  assign data_end = quiet && cond.scl_fall && state_r == ST_DATA
                    && bit_cnt_r == `ISRB_BITS_BYTE;
  assign addr_end = quiet && cond.scl_fall && state_r == ST_ADDR
                    && bit_cnt_r == `ISRB_BITS_BYTE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !ce);

  ack_all_a: assert property (data_end && !lb_r |=> !sda_oe_n_r)
    else $error("data byte not acknowledged");
  count_cap_a: assert property (
    state_r inside {ST_DATA, ST_DATA_ACK} && bc_r != 7'h00
    |-> rx_cnt_r <= bc_r)
    else $error("more bytes than byte_count");
  last_nack_a: assert property (
    data_end && lb_r && last_w |=> sda_oe_n_r && state_r == ST_DATA_ACK)
    else $error("last byte not left high");
  aa_ignore_a: assert property (
    addr_end && !aa_r && !gc_hit |=> state_r == ST_IGNORE && sda_oe_n_r)
    else $error("address answered with ack enable clear");
  aa_resume_a: assert property (
    addr_end && own_hit
    |=> state_r == ST_ADDR_ACK && !sda_oe_n_r)
    else $error("own address not recognised after enable");
  arb_code_a: assert property (
    quiet && cond.scl_fall && state_r == ST_ADDR_ACK && arb_lost
    |=> status_r inside {`ISRB_SC_ARB_SLA_W, `ISRB_SC_ARB_GC}
        ##1 ce && state_r == ST_HOLD && !scl_oe_n_r)
    else $error("arbitration-lost code or hold wrong");
  only_last_a: assert property (
    data_end && !last_w |=> !sda_oe_n_r [*1] ##1 !cond.scl_fall
    || state_r != ST_DATA_ACK || !sda_oe_n_r)
    else $error("non-final byte nacked");
  early_end_a: assert property (
    ce && cond.stop && state_r == ST_DATA
    |=> state_r == ST_IDLE && status_r == `ISRB_SC_STOP && si_r)
    else $error("early stop not taken");
  own_60_a: assert property (
    quiet && cond.scl_fall && state_r == ST_ADDR_ACK && !gc_r
    && !arb_lost |=> si_r && !int_n_r && status_r == `ISRB_SC_SLA_W)
    else $error("own write address not reported");
  gc_d0_a: assert property (
    quiet && cond.scl_fall && state_r == ST_ADDR_ACK && gc_r
    && !arb_lost |=> si_r && status_r == `ISRB_SC_GC)
    else $error("general call not reported");

  addr_c: cover property (state_r == ST_ADDR_ACK ##1 state_r == ST_HOLD);
  seq_c:  cover property (ev[`ISRB_IRQ_SEQ] && acked_r);
  nack_c: cover property (ev[`ISRB_IRQ_SEQ] && !acked_r);
  stop_c: cover property (ev[`ISRB_IRQ_STOP]);
endmodule

/* File: rtl/isrb_regs.svh */
`ifndef ISRB_REGS_SVH
`define ISRB_REGS_SVH
`define ISRB_OFS_CTRL      5'h00
`define ISRB_OFS_STATUS    5'h04
`define ISRB_OFS_XFER      5'h08
`define ISRB_OFS_OWNADR    5'h0C
`define ISRB_OFS_DATA      5'h10
`define ISRB_OFS_IRQ_STAT  5'h14
`define ISRB_OFS_IRQ_MASK  5'h18
`define ISRB_OFS_RXCNT     5'h1C
`define ISRB_CTRL_AA       7
`define ISRB_CTRL_EN       6
`define ISRB_CTRL_SI       3
`define ISRB_CTRL_MODE     0
`define ISRB_XFER_LB       7
`define ISRB_OWN_GC        0
`define ISRB_CTRL_RST      8'h00
`define ISRB_XFER_RST      8'h00
`define ISRB_OWNADR_RST    8'h00
`define ISRB_MASK_RST      3'h0
`define ISRB_IRQ_ADDR      0
`define ISRB_IRQ_SEQ       1
`define ISRB_IRQ_STOP      2
`define ISRB_SC_IDLE       8'hF8
`define ISRB_SC_SLA_W      8'h60
`define ISRB_SC_ARB_SLA_W  8'h68
`define ISRB_SC_GC         8'hD0
`define ISRB_SC_ARB_GC     8'hD8
`define ISRB_SC_RX_ACK     8'h80
`define ISRB_SC_RX_NACK    8'h88
`define ISRB_SC_STOP       8'hA0
`define ISRB_GC_ADDR       8'h00
`define ISRB_BUF_DEPTH     7'h44
`define ISRB_BITS_BYTE     4'h8
`endif

/* File: rtl/isrb_pkg.sv */
package isrb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_HOLD     = 3'h2,
    ST_DATA     = 3'h6,
    ST_DATA_ACK = 3'h7,
    ST_IGNORE   = 3'h5
  } isrb_state_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } isrb_bus_req_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } isrb_cond_t;
endpackage

/* File: rtl/isrb_sync3.sv */
`timescale 1ns/1ns
module isrb_sync3 (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] level
);
  logic [1:0] ff1_r, ff2_r, ff3_r, lvl_r;

  // Bus idles high, so every stage resets to one
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          ff1_r[i] <= 1'b1;
          ff2_r[i] <= 1'b1;
          ff3_r[i] <= 1'b1;
          lvl_r[i] <= 1'b1;
        end else if (ce) begin
          ff1_r[i] <= pin_in[i];
          ff2_r[i] <= ff1_r[i];
          ff3_r[i] <= ff2_r[i];
          if (ff2_r[i] == ff3_r[i]) begin
            lvl_r[i] <= ff3_r[i];
          end
        end
      end
    end
  endgenerate

  assign level = lvl_r;
endmodule

/* File: rtl/isrb_cond_det.sv */
`timescale 1ns/1ns
module isrb_cond_det
  import isrb_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic scl,
  input  wire logic sda,
  output isrb_cond_t cond
);
  logic scl_q_r, sda_q_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (ce) begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // Pulses are qualified by ce so a frozen block sees no events
  always_comb begin
    cond.scl_rise = ce && scl && !scl_q_r;
    cond.scl_fall = ce && !scl && scl_q_r;
    cond.start    = ce && scl && scl_q_r && sda_q_r && !sda;
    cond.stop     = ce && scl && scl_q_r && !sda_q_r && sda;
  end
endmodule

/* File: dv/isrb_i2c_master.sv */
`timescale 1ns/1ns
module isrb_i2c_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // Open-drain drivers; both lines idle high through bench pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Keep every pin change off the core clock's rising edges, so the
  // slave's sampler never races the model
  task automatic align();
    if (($time % 10) == 0) begin
      #5;
    end
  endtask
  // Slave may stretch the clock, so wait on the wire, bounded
  task automatic scl_up(input int hi);
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 3000) begin
      #10;
      n++;
    end
    #(hi);
  endtask
  task automatic start();
    align();
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
  endtask
  task automatic stop();
    align();
    #20;
    sda_low = 1'b1;
    #100;
    scl_up(80);
    sda_low = 1'b0;
    #80;
  endtask
  // 160 ns bit time; low phase long enough to outlast the slave's
  // delayed release of its acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    align();
    for (int i = 7; i >= 0; i--) begin
      #110;
      sda_low = ~b[i];
      #10;
      scl_up(40);
      scl_low = 1'b1;
    end
    #110;
    sda_low = 1'b0;
    #10;
    scl_up(40);
    ack = (sda === 1'b0);
    scl_low = 1'b1;
  endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
`include "isrb_regs.svh"
module testbench
  import isrb_pkg::*;
;
  localparam logic [6:0] OWN_ADR = 7'h5A;
  logic          core_clk;
  logic          rst_n;
  logic          ce;
  isrb_bus_req_t bus_req;
  logic [7:0]    rdata;
  logic          arb_lost;
  logic          scl_oe_n;
  logic          sda_oe_n;
  logic          int_n;
  logic          irq;
  logic          m_scl_low;
  logic          m_sda_low;
  logic          rd_d;
  logic [31:0]   lfsr;
  logic [7:0]    exp_q[$];
  int            num_errors;
  int            checks;
  int            cyc;
  // Pull-ups: a released line reads high
  wire           scl = ~(m_scl_low | ~scl_oe_n);
  wire           sda = ~(m_sda_low | ~sda_oe_n);

  isrb_slave_rx uut (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .bus_req  (bus_req),
    .rdata    (rdata),
    .scl_in   (scl),
    .sda_in   (sda),
    .arb_lost (arb_lost),
    .scl_out  (),
    .scl_oe_n (scl_oe_n),
    .sda_out  (),
    .sda_oe_n (sda_oe_n),
    .int_n    (int_n),
    .irq      (irq)
  );
  isrb_i2c_master mst (
    .scl     (scl),
    .sda     (sda),
    .scl_low (m_scl_low),
    .sda_low (m_sda_low)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t: pin %b expected %b", $time, got, exp);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= bus_req.rd;
    cyc <= cyc + 1;
    if (rd_d && exp_q.size() > 0) cmp_reg(rdata, exp_q.pop_front());
    if (cyc == 30000) begin
      num_errors++;
      $display("FAIL %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
  endtask

  task automatic wait_int();
    int n;
    n = 0;
    while (int_n !== 1'b0 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic clean();
    repeat (20) @(posedge core_clk);
    reg_wr(`ISRB_OFS_CTRL, 8'hC0);
    reg_wr(`ISRB_OFS_IRQ_STAT, 8'h07);
    repeat (3) @(posedge core_clk);
    cmp_bit(int_n, 1'b1);
    cmp_bit(irq, 1'b0);
  endtask

  task automatic addr_ph(input logic [7:0] ab, input logic arb,
                         input logic ack_e, input logic [7:0] sc);
    logic a;
    @(posedge core_clk);
    arb_lost <= arb;
    mst.start();
    mst.send_byte(ab, a);
    cmp_bit(a, ack_e);
    wait_int();
    cmp_bit(int_n, ~ack_e);
    cmp_bit(scl_oe_n, ~ack_e);
    if (ack_e) begin
      reg_rd(`ISRB_OFS_STATUS, sc);
      reg_rd(`ISRB_OFS_IRQ_STAT, 8'h01);
    end else begin
      mst.stop();
      clean();
    end
    @(posedge core_clk);
    arb_lost <= 1'b0;
  endtask

  // Host answers the addressing code, then the master sends bytes
  task automatic seq(input logic lb, input logic [6:0] cnt,
                     input int nsend, input logic [7:0] sc);
    logic       a;
    logic [7:0] b[$];
    reg_wr(`ISRB_OFS_XFER, {lb, cnt});
    reg_wr(`ISRB_OFS_CTRL, 8'hC1);
    for (int i = 0; i < nsend; i++) begin
      lfsr = lfsr_next(lfsr);
      b.push_back(lfsr[7:0]);
      mst.send_byte(lfsr[7:0], a);
      cmp_bit(a, !(lb && i == int'(cnt) - 1));
    end
    if (nsend < int'(cnt)) mst.stop();
    wait_int();
    // Only a fully acknowledged sequence holds the clock low
    cmp_bit(scl_oe_n, sc != `ISRB_SC_RX_ACK);
    reg_rd(`ISRB_OFS_STATUS, sc);
    reg_rd(`ISRB_OFS_RXCNT, 8'(nsend));
    foreach (b[i]) reg_rd(`ISRB_OFS_DATA, b[i]);
    // An acknowledged full sequence leaves the clock stretched until the host answers
    if (nsend == int'(cnt)) begin
      reg_wr(`ISRB_OFS_CTRL, 8'hC1);
      mst.stop();
    end
    clean();
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus_req = '0;
    arb_lost = 1'b0;
    rd_d = 1'b0;
    lfsr = 32'h7AC46A32;
    num_errors = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    reg_rd(`ISRB_OFS_STATUS, `ISRB_SC_IDLE);
    reg_rd(`ISRB_OFS_CTRL, `ISRB_CTRL_RST);
    reg_rd(`ISRB_OFS_XFER, `ISRB_XFER_RST);
    reg_rd(`ISRB_OFS_IRQ_MASK, 8'h00);
    reg_wr(`ISRB_OFS_STATUS, 8'h00);
    reg_rd(`ISRB_OFS_STATUS, `ISRB_SC_IDLE);
    reg_wr(5'h02, 8'hFF);
    reg_rd(5'h02, 8'h00);
    reg_wr(`ISRB_OFS_OWNADR, {OWN_ADR, 1'b1});
    reg_rd(`ISRB_OFS_OWNADR, {OWN_ADR, 1'b1});
    // A frozen block must ignore a write strobe
    ce <= 1'b0;
    reg_wr(`ISRB_OFS_OWNADR, 8'h00);
    ce <= 1'b1;
    reg_rd(`ISRB_OFS_OWNADR, {OWN_ADR, 1'b1});
    reg_wr(`ISRB_OFS_CTRL, 8'h40);
    addr_ph({OWN_ADR, 1'b0}, 1'b0, 1'b0, 8'h00);
    reg_wr(`ISRB_OFS_CTRL, 8'hC0);
    addr_ph({OWN_ADR, 1'b1}, 1'b0, 1'b0, 8'h00);
    addr_ph({OWN_ADR, 1'b0}, 1'b0, 1'b1, `ISRB_SC_SLA_W);
    // Masked event keeps the level low until the mask opens
    cmp_bit(irq, 1'b0);
    reg_wr(`ISRB_OFS_IRQ_MASK, 8'h07);
    repeat (2) @(posedge core_clk);
    cmp_bit(irq, 1'b1);
    seq(1'b0, 7'h03, 3, `ISRB_SC_RX_ACK);
    addr_ph({OWN_ADR, 1'b0}, 1'b1, 1'b1, `ISRB_SC_ARB_SLA_W);
    seq(1'b1, 7'h02, 2, `ISRB_SC_RX_NACK);
    addr_ph(`ISRB_GC_ADDR, 1'b0, 1'b1, `ISRB_SC_GC);
    seq(1'b1, 7'h04, 2, `ISRB_SC_STOP);
    addr_ph(`ISRB_GC_ADDR, 1'b1, 1'b1, `ISRB_SC_ARB_GC);
    seq(1'b0, 7'h01, 1, `ISRB_SC_RX_ACK);
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule
